// *** logic/scs_status.sv ***
// Status registers and event latching for one serial channel
//
// How it works
// [R1] Receive-available bit while buffer not empty
// [R2] Interrupt-pending bit, first channel only
// [R3] Transmit-empty set on drain or reset
// [R4] Transmit-empty held low during check character
// [R5] Carrier bit frozen while external interrupt
// [R6] Async: align level shown, change interrupts
// [R7] Far side waits two receive clocks
// [R8] External sync: align low updates hunt
// [R9] External sync: loss or end rehunts
// [R10] Mono/bisync: hunt command sets, sync clears
// [R11] Bit mode: disable/hunt sets, flag clears
// [R12] Clear-to-send bit is inverted pin
// [R13] Underrun bit set on reset, command clears
// [R14] Underrun raises external/status interrupt
// [R15] Async break sets bit, interrupt, command clears
// [R16] Break end interrupts again
// [R17] Bit mode abort sets bit, interrupts
// [R18] Special status bit layout fixed
// [R19] Parity error latched until error reset
// [R20] End-of-frame bit mode only, next-frame update
// [R21] Status registers ignore writes
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps

`include "scs_defines.svh"

module scs_status #(
  parameter bit IS_FIRST_CHANNEL = 1'b1
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Link pins
  input  wire logic       carrier_detect_input_n,
  input  wire logic       clear_to_send_n,
  input  wire logic       frame_align_n,
  input  wire logic       receive_clock_input,
  // Receiver events
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       rx_parity_bad,
  input  wire logic       rx_framing_bad,
  input  wire logic       rx_frame_end,
  input  wire logic [2:0] rx_residue,
  input  wire logic       rx_break,
  input  wire logic       rx_abort,
  input  wire logic       rx_sync_found,
  input  wire logic       rx_flag_found,
  input  wire logic       rx_sync_lost,
  input  wire logic       rx_msg_end,
  // Transmitter
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_taken,
  input  wire logic       tx_crc_active,
  input  wire logic       tx_underrun,
  input  wire logic       tx_all_sent,
  // Rest of the controller
  input  wire logic       other_int_pending
);

  import scs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  scs_state_t q;
  scs_state_t next_q;

  // Pin indices in the synchroniser vectors
  localparam int PIN_CARRIER = 0;
  localparam int PIN_CTS     = 1;
  localparam int PIN_ALIGN   = 2;
  localparam int PIN_RXC     = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  scs_mode_t mode;
  logic      is_async;
  logic      is_charsync;
  logic      is_sdlc;
  logic      is_ext;
  logic      wr_cmd;
  logic      wr_mode;
  logic      wr_tx;
  logic      rd_rx;
  logic [2:0] cmd_code;
  logic      cmd_reset_ext;
  logic      cmd_chan_reset;
  logic      cmd_error_reset;
  logic      cmd_underrun_clr;
  logic      enter_hunt;
  logic      rx_disable;

  always_comb begin
    mode        = scs_mode_t'(q.mode[`SCS_MODE_HI:`SCS_MODE_LO]);
    is_async    = (mode == SCS_MODE_ASYNC);
    is_charsync = (mode == SCS_MODE_MONO) || (mode == SCS_MODE_BI);
    is_sdlc     = (mode == SCS_MODE_SDLC);
    is_ext      = (mode == SCS_MODE_EXT);
    wr_cmd      = reg_wr && (reg_addr == `SCS_OFS_COMMAND);
    wr_mode     = reg_wr && (reg_addr == `SCS_OFS_MODE);
    wr_tx       = reg_wr && (reg_addr == `SCS_OFS_TX_DATA);
    rd_rx       = reg_rd && (reg_addr == `SCS_OFS_RX_DATA);
    cmd_code    = reg_wdata[`SCS_CMD_HI:`SCS_CMD_LO];
    cmd_reset_ext   = wr_cmd && (cmd_code == `SCS_CMD_RESET_EXT);
    cmd_chan_reset  = wr_cmd && (cmd_code == `SCS_CMD_CHAN_RESET);
    cmd_error_reset = wr_cmd && (cmd_code == `SCS_CMD_ERROR_RESET);
    // [R13] dedicated latch reset code
    cmd_underrun_clr = wr_cmd &&
      (reg_wdata[`SCS_LATCH_HI:`SCS_LATCH_LO] == `SCS_LATCH_UNDERRUN);
    enter_hunt  = wr_mode && reg_wdata[`SCS_MODE_ENTER_HUNT];
    rx_disable  = wr_mode && !reg_wdata[`SCS_MODE_RX_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges, read only from the second stage onward

  logic carrier_live;
  logic cts_live;
  logic align_live;
  logic carrier_chg;
  logic cts_chg;
  logic align_chg;
  logic rxc_rise;

  always_comb begin
    carrier_live = !q.pin_sync[PIN_CARRIER];
    cts_live     = !q.pin_sync[PIN_CTS];
    align_live   = !q.pin_sync[PIN_ALIGN];
    carrier_chg  = q.pin_sync[PIN_CARRIER] ^ q.pin_prev[PIN_CARRIER];
    cts_chg      = q.pin_sync[PIN_CTS] ^ q.pin_prev[PIN_CTS];
    align_chg    = q.pin_sync[PIN_ALIGN] ^ q.pin_prev[PIN_ALIGN];
    rxc_rise     = q.pin_sync[PIN_RXC] && !q.pin_prev[PIN_RXC];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events feeding the external/status latch

  logic brk_rise;
  logic brk_fall;
  logic ext_event;

  always_comb begin
    brk_rise  = is_async && rx_break && !q.brk_prev;
    brk_fall  = is_async && !rx_break && q.brk_prev;
    // [R6] align change in async mode
    // [R14] underrun event
    // [R16] break end as well as start
    ext_event = carrier_chg || cts_chg ||
                (is_async && align_chg) ||
                tx_underrun || brk_rise || brk_fall ||
                (is_sdlc && rx_abort);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read views

  logic [7:0] primary;
  logic [7:0] special;
  logic       hunt_bit;

  always_comb begin
    hunt_bit = is_async ? q.align_level : (q.hunt == SCS_HUNTING);
    primary  = 8'h00;
    // [R1] buffer holds a character
    primary[`SCS_PRI_RX_AVAIL] = (q.rx_count != 2'h0);
    // [R2] any pending interrupt, first channel only
    primary[`SCS_PRI_INT_PEND] = IS_FIRST_CHANNEL &&
                                 (q.ext_pending || other_int_pending);
    // [R3] empty after drain or reset
    // [R4] not empty while check character goes out
    primary[`SCS_PRI_TX_EMPTY] = !q.tx_valid &&
                                 !(!is_async && tx_crc_active);
    primary[`SCS_PRI_CARRIER]  = q.carrier;
    primary[`SCS_PRI_HUNT]     = hunt_bit;
    // [R12] inverse of the pin
    primary[`SCS_PRI_CTS]      = cts_live;
    primary[`SCS_PRI_UNDERRUN] = q.underrun;
    primary[`SCS_PRI_BREAK]    = q.brk;

    // [R18] special receive layout
    special = 8'h00;
    special[`SCS_SPC_ALL_SENT] = tx_all_sent || !is_async;
    special[`SCS_SPC_RESIDUE_HI:`SCS_SPC_RESIDUE_LO] = q.residue;
    special[`SCS_SPC_PARITY]    = q.parity_err;
    special[`SCS_SPC_OVERRUN]   = q.overrun;
    special[`SCS_SPC_FRAMING]   = (q.rx_count != 2'h0) && q.rx_buf[0][8];
    special[`SCS_SPC_END_FRAME] = q.end_frame;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [1:0] cnt_after_pop;

  always_comb begin
    next_q = q;
    cnt_after_pop = q.rx_count;

    // Two flops on every pin, then an edge history stage
    next_q.pin_meta = {receive_clock_input, frame_align_n,
                       clear_to_send_n, carrier_detect_input_n};
    next_q.pin_sync = q.pin_meta;
    next_q.pin_prev = q.pin_sync;
    next_q.brk_prev = rx_break;

    // Register reads, answered in the following cycle
    next_q.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SCS_OFS_PRIMARY: next_q.rdata = primary;
        `SCS_OFS_SPECIAL: next_q.rdata = special;
        `SCS_OFS_MODE:    next_q.rdata = q.mode;
        `SCS_OFS_RX_DATA: next_q.rdata = q.rx_buf[0][7:0];
        default:          next_q.rdata = 8'h00;
      endcase
    end

    // [R21] writes to status offsets fall through, nothing stored
    if (wr_mode) begin
      next_q.mode = reg_wdata & 8'h1f;
    end

    // Transmit buffer; a new write wins over the take
    if (tx_taken) begin
      next_q.tx_valid = 1'b0;
    end
    if (wr_tx) begin
      next_q.tx_data  = reg_wdata;
      next_q.tx_valid = 1'b1;
    end

    // Receive buffer, shift-down order, oldest at entry 0
    if (rd_rx && (q.rx_count != 2'h0)) begin
      next_q.rx_buf[0] = q.rx_buf[1];
      next_q.rx_buf[1] = q.rx_buf[2];
      next_q.rx_buf[2] = 9'h000;
      cnt_after_pop    = q.rx_count - 2'h1;
      next_q.rx_count  = cnt_after_pop;
    end

    // Error clears first so a same-cycle error still sets
    if (cmd_error_reset) begin
      next_q.parity_err = 1'b0;
      next_q.overrun    = 1'b0;
      next_q.end_frame  = 1'b0;
    end

    if (rx_char_valid && q.mode[`SCS_MODE_RX_EN]) begin
      if (cnt_after_pop < `SCS_RX_DEPTH) begin
        next_q.rx_buf[cnt_after_pop] = {rx_framing_bad, rx_char_data};
        next_q.rx_count = cnt_after_pop + 2'h1;
      end else begin
        // Newest character overwrites the last slot
        next_q.rx_buf[2] = {rx_framing_bad, rx_char_data};
        next_q.overrun   = 1'b1;
      end
      // [R19] sticky parity error
      if (q.mode[`SCS_MODE_PARITY_EN] && rx_parity_bad) begin
        next_q.parity_err = 1'b1;
      end
      // [R20] first character of next frame updates flag
      if (is_sdlc && !rx_frame_end) begin
        next_q.end_frame = 1'b0;
      end
    end

    // [R20] end of frame only in bit mode
    if (is_sdlc && rx_frame_end) begin
      next_q.end_frame = 1'b1;
      next_q.residue   = rx_residue;
    end

    // External/status latch; command clear loses to a new event
    if (cmd_reset_ext) begin
      next_q.ext_pending = 1'b0;
      next_q.brk         = 1'b0;
    end
    if (ext_event) begin
      next_q.ext_pending = 1'b1;
    end

    // [R5] carrier follows the pin until the latch is set
    // [R6] async align level frozen likewise
    if (!q.ext_pending || cmd_reset_ext) begin
      next_q.carrier     = carrier_live;
      next_q.align_level = align_live;
    end

    // [R15] break sets bit in async reception
    if (brk_rise) begin
      next_q.brk = 1'b1;
    end
    // [R17] abort sets bit in bit mode
    if (is_sdlc && rx_abort) begin
      next_q.brk = 1'b1;
    end

    // [R13] only the dedicated command clears
    if (cmd_underrun_clr) begin
      next_q.underrun = 1'b0;
    end
    if (tx_underrun) begin
      next_q.underrun = 1'b1;
    end

    // Hunt tracking per mode
    case (mode)
      SCS_MODE_EXT: begin
        // [R8] align low, sampled on receive clock rise
        if (rxc_rise && align_live) begin
          next_q.hunt = SCS_SYNCED;
        end
        // [R9] loss or end of message
        if (rx_sync_lost || rx_msg_end) begin
          next_q.hunt = SCS_HUNTING;
        end
      end
      SCS_MODE_MONO,
      SCS_MODE_BI: begin
        // [R10] sync found clears, hunt command forces one
        if (rx_sync_found) begin
          next_q.hunt = SCS_SYNCED;
        end
        if (enter_hunt) begin
          next_q.hunt = SCS_HUNTING;
        end
      end
      SCS_MODE_SDLC: begin
        // [R11] opening flag clears, disable or hunt sets
        if (rx_flag_found) begin
          next_q.hunt = SCS_SYNCED;
        end
        if (enter_hunt || rx_disable) begin
          next_q.hunt = SCS_HUNTING;
        end
      end
      default: begin
        next_q.hunt = q.hunt;
      end
    endcase

    // Channel reset leaves the mode register alone
    if (cmd_chan_reset) begin
      next_q.tx_valid    = 1'b0;
      next_q.rx_count    = 2'h0;
      next_q.rx_buf      = '0;
      next_q.parity_err  = 1'b0;
      next_q.overrun     = 1'b0;
      next_q.end_frame   = 1'b0;
      next_q.residue     = 3'h0;
      next_q.ext_pending = 1'b0;
      next_q.brk         = 1'b0;
      next_q.hunt        = SCS_HUNTING;
      // [R3] empty on reset
      // [R13] underrun set on channel reset
      next_q.underrun    = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q             <= '0;
      // Active-low pins idle high, receive clock low; avoids a false edge after reset
      q.pin_meta    <= 4'h7;
      q.pin_sync    <= 4'h7;
      q.pin_prev    <= 4'h7;
      q.mode        <= `SCS_MODE_RESET;
      q.hunt        <= SCS_HUNTING;
      // [R13] underrun set on controller reset
      q.underrun    <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_comb begin
    reg_rdata = q.rdata;
    tx_data   = q.tx_data;
    tx_valid  = q.tx_valid;
  end

endmodule : scs_status

// *** logic/scs_defines.svh ***
// Offsets, field positions, command codes and reset values of the channel
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

// Register offsets
`define SCS_OFS_PRIMARY      3'h0
`define SCS_OFS_SPECIAL      3'h1
`define SCS_OFS_COMMAND      3'h2
`define SCS_OFS_MODE         3'h3
`define SCS_OFS_RX_DATA      3'h4
`define SCS_OFS_TX_DATA      3'h5

// Primary status bits
`define SCS_PRI_RX_AVAIL     0
`define SCS_PRI_INT_PEND     1
`define SCS_PRI_TX_EMPTY     2
`define SCS_PRI_CARRIER      3
`define SCS_PRI_HUNT         4
`define SCS_PRI_CTS          5
`define SCS_PRI_UNDERRUN     6
`define SCS_PRI_BREAK        7

// Special receive status bits
`define SCS_SPC_ALL_SENT     0
`define SCS_SPC_RESIDUE_LO   1
`define SCS_SPC_RESIDUE_HI   3
`define SCS_SPC_PARITY       4
`define SCS_SPC_OVERRUN      5
`define SCS_SPC_FRAMING      6
`define SCS_SPC_END_FRAME    7

// Command register fields and codes
`define SCS_CMD_LO           3
`define SCS_CMD_HI           5
`define SCS_LATCH_LO         6
`define SCS_LATCH_HI         7
`define SCS_CMD_RESET_EXT    3'h2
`define SCS_CMD_CHAN_RESET   3'h3
`define SCS_CMD_ERROR_RESET  3'h6
`define SCS_LATCH_UNDERRUN   2'h3

// Mode register fields
`define SCS_MODE_LO          0
`define SCS_MODE_HI          2
`define SCS_MODE_PARITY_EN   3
`define SCS_MODE_RX_EN       4
`define SCS_MODE_ENTER_HUNT  5
`define SCS_MODE_RESET       8'h00

// Receive buffer depth
`define SCS_RX_DEPTH         2'h3

`endif

// *** logic/scs_pkg.sv ***
// Types shared by the channel status block
package scs_pkg;

  typedef enum logic [2:0] {
    SCS_MODE_ASYNC = 3'h0,
    SCS_MODE_MONO  = 3'h1,
    SCS_MODE_BI    = 3'h2,
    SCS_MODE_SDLC  = 3'h3,
    SCS_MODE_EXT   = 3'h4
  } scs_mode_t;

  typedef enum logic [1:0] {
    SCS_HUNTING = 2'b01,
    SCS_SYNCED  = 2'b10
  } scs_hunt_t;

  typedef struct packed {
    logic [3:0]      pin_meta;
    logic [3:0]      pin_sync;
    logic [3:0]      pin_prev;
    logic [7:0]      rdata;
    logic [7:0]      mode;
    logic [7:0]      tx_data;
    logic            tx_valid;
    logic [2:0][8:0] rx_buf;
    logic [1:0]      rx_count;
    logic            parity_err;
    logic            overrun;
    logic            end_frame;
    logic [2:0]      residue;
    logic            ext_pending;
    logic            carrier;
    logic            align_level;
    scs_hunt_t       hunt;
    logic            underrun;
    logic            brk;
    logic            brk_prev;
  } scs_state_t;

endpackage : scs_pkg

// *** bench/scs_status_assertions.sv ***
// Port checker for the channel status block
`timescale 1ns/1ps

module scs_status_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and events
  input wire logic       carrier_detect_input_n,
  input wire logic       clear_to_send_n,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_taken,
  input wire logic       tx_underrun,
  input wire logic       other_int_pending
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic rd0;
  assign rd0 = reg_rd && reg_addr == 3'h0;

  ////////////////////////////////////////////////////////////////////////
  chk_reset_status: assert property (
    $past(sys_rst) && rd0 |=> reg_rdata[6] && reg_rdata[2]
  ) else $error("status after reset lacks underrun or empty");

  chk_tx_load: assert property (
    reg_wr && reg_addr == 3'h5 |=> tx_valid && tx_data == $past(reg_wdata)
  ) else $error("transmit byte not held after write");

  chk_tx_drain: assert property (
    tx_valid && tx_taken && !reg_wr |=> !tx_valid
  ) else $error("transmit buffer not drained when taken");

  chk_status_ro: assert property (
    reg_wr && reg_addr < 3'h2 && !tx_valid |=> !tx_valid
  ) else $error("status write disturbed the channel");

  chk_cts_inverse: assert property (
    ($stable(clear_to_send_n))[*5] ##0 rd0
      |=> reg_rdata[5] == !$past(clear_to_send_n)
  ) else $error("clear-to-send bit not the inverted pin");

  chk_carrier_live: assert property (
    ($stable(carrier_detect_input_n))[*5] ##0 (rd0 && !other_int_pending)
      |=> reg_rdata[1] || reg_rdata[3] == !$past(carrier_detect_input_n)
  ) else $error("carrier bit wrong with nothing pending");

  chk_int_pending: assert property (
    rd0 && other_int_pending && $past(other_int_pending) |=> reg_rdata[1]
  ) else $error("pending bit clear while interrupt pending");

  chk_underrun_event: assert property (
    tx_underrun ##1 !reg_wr ##1 rd0 |=> reg_rdata[6] && reg_rdata[1]
  ) else $error("underrun did not raise status event");
endmodule : scs_status_checker

bind scs_status scs_status_checker u_chk (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .carrier_detect_input_n(carrier_detect_input_n),
  .clear_to_send_n(clear_to_send_n), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_taken(tx_taken), .tx_underrun(tx_underrun),
  .other_int_pending(other_int_pending)
);

// *** bench/scs_link_model.sv ***
// Remote station and modem lines facing the channel
`timescale 1ns/1ps

module scs_link_model (
  // Wanted line levels
  input  wire logic run,
  input  wire logic cd_n,
  input  wire logic cts_n,
  input  wire logic align_n,
  input  wire logic sync_req,
  // Lines toward the channel
  output logic      carrier_detect_input_n,
  output logic      clear_to_send_n,
  output logic      frame_align_n,
  output logic      receive_clock_input
);
  logic synced;

  // Clock stands still outside frames
  initial receive_clock_input = 1'b0;
  always #62.5 receive_clock_input = run ? ~receive_clock_input : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // two receive clocks first
  initial synced = 1'b0;
  always begin
    @(posedge sync_req);
    @(posedge receive_clock_input);
    repeat (2) @(negedge receive_clock_input);
    synced = 1'b1;
    @(negedge sync_req);
    synced = 1'b0;
  end

  assign frame_align_n          = synced ? 1'b0 : align_n;
  assign carrier_detect_input_n = cd_n;
  assign clear_to_send_n        = cts_n;
endmodule : scs_link_model

// *** bench/serial_channel_status_regs_tb.sv ***
// Self-checking bench for the channel status block
`timescale 1ns/1ps

module serial_channel_status_regs_tb;
  logic       clock, sys_rst, reg_wr, reg_rd, tx_crc_active, other_int_pending;
  logic       rx_parity_bad, rx_break, run, cd_n, cts_n, al_n, sync_req;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, rx_char_data, reg_rdata, tx_data;
  logic [8:0] ev;
  logic       tx_valid, cd_pin, cts_pin, al_pin, rclk;
  int         err_count, n_compared;

  scs_link_model u_link (.run(run), .cd_n(cd_n), .cts_n(cts_n),
    .align_n(al_n), .sync_req(sync_req), .carrier_detect_input_n(cd_pin),
    .clear_to_send_n(cts_pin), .frame_align_n(al_pin),
    .receive_clock_input(rclk));

  // Event bits: char, abort, sync, flag, lost, underrun, taken, end, msg
  scs_status DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .carrier_detect_input_n(cd_pin),
    .clear_to_send_n(cts_pin), .frame_align_n(al_pin),
    .receive_clock_input(rclk), .rx_char_valid(ev[0]),
    .rx_char_data(rx_char_data), .rx_parity_bad(rx_parity_bad),
    .rx_framing_bad(1'b0), .rx_frame_end(ev[7]), .rx_residue(3'h5),
    .rx_break(rx_break), .rx_abort(ev[1]), .rx_sync_found(ev[2]),
    .rx_flag_found(ev[3]), .rx_sync_lost(ev[4]), .rx_msg_end(ev[8]),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_taken(ev[6]),
    .tx_crc_active(tx_crc_active), .tx_underrun(ev[5]),
    .tx_all_sent(1'b1), .other_int_pending(other_int_pending));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdm(input logic [2:0] a, input logic [7:0] m, e);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rdm

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic settle;
    repeat (5) @(posedge clock);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (4) @(posedge clock);
    sys_rst  <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= 3'h0;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h44);
    rdm(3'h1, 8'hff, 8'h01);
    rdm(3'h7, 8'hff, 8'h00);
    wr(3'h0, 8'hff);
    wr(3'h1, 8'hff);
    rdm(3'h0, 8'hff, 8'h44);
    @(posedge clock) other_int_pending <= 1'b1;
    rdm(3'h0, 8'h02, 8'h02);
    other_int_pending <= 1'b0;
    $display("test reset done");
  endtask : t_reset

  task automatic t_tx;
    wr(3'h5, 8'ha5);
    #1 chk(tx_data, 8'ha5);
    rdm(3'h0, 8'h04, 8'h00);
    pulse(6);
    rdm(3'h0, 8'h04, 8'h04);
    wr(3'h3, 8'h02);
    @(posedge clock) tx_crc_active <= 1'b1;
    rdm(3'h0, 8'h04, 8'h00);
    tx_crc_active <= 1'b0;
    wr(3'h2, 8'hc0);
    rdm(3'h0, 8'h40, 8'h00);
    pulse(5);
    rdm(3'h0, 8'h42, 8'h42);
    wr(3'h2, 8'h10);
    rdm(3'h0, 8'h42, 8'h40);
    // Channel reset refills the underrun latch and drops a held byte
    wr(3'h2, 8'hc0);
    wr(3'h5, 8'h5a);
    wr(3'h2, 8'h18);
    rdm(3'h0, 8'h44, 8'h44);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_async;
    wr(3'h3, 8'h18);
    @(posedge clock) rx_char_data <= 8'h3c;
    rx_parity_bad <= 1'b1;
    pulse(0);
    rdm(3'h0, 8'h01, 8'h01);
    rdm(3'h4, 8'hff, 8'h3c);
    rdm(3'h0, 8'h01, 8'h00);
    rdm(3'h1, 8'h10, 8'h10);
    wr(3'h2, 8'h30);
    rdm(3'h1, 8'h10, 8'h00);
    @(posedge clock) rx_break <= 1'b1;
    rdm(3'h0, 8'h82, 8'h82);
    wr(3'h2, 8'h10);
    rdm(3'h0, 8'h82, 8'h00);
    @(posedge clock) rx_break <= 1'b0;
    rdm(3'h0, 8'h02, 8'h02);
    wr(3'h2, 8'h10);
    @(posedge clock) al_n <= 1'b0;
    settle;
    rdm(3'h0, 8'h12, 8'h12);
    // Unfreeze carrier before it moves
    wr(3'h2, 8'h10);
    @(posedge clock) cts_n <= 1'b0;
    cd_n <= 1'b0;
    settle;
    rdm(3'h0, 8'h2a, 8'h2a);
    @(posedge clock) cd_n <= 1'b1;
    settle;
    rdm(3'h0, 8'h08, 8'h08);
    $display("test async done");
  endtask : t_async

  task automatic t_hunt;
    // Align pin high again, else external sync locks at once
    @(posedge clock) al_n <= 1'b1;
    for (int m = 1; m < 3; m++) begin
      wr(3'h3, 8'h30 | m[7:0]);
      rdm(3'h0, 8'h10, 8'h10);
      pulse(2);
      rdm(3'h0, 8'h10, 8'h00);
    end
    wr(3'h3, 8'h33);
    rdm(3'h0, 8'h10, 8'h10);
    pulse(3);
    rdm(3'h0, 8'h10, 8'h00);
    wr(3'h3, 8'h03);
    rdm(3'h0, 8'h10, 8'h10);
    wr(3'h2, 8'h10);
    pulse(1);
    rdm(3'h0, 8'h80, 8'h80);
    pulse(7);
    rdm(3'h1, 8'hff, 8'h8b);
    wr(3'h3, 8'h13);
    pulse(0);
    rdm(3'h1, 8'h80, 8'h00);
    wr(3'h3, 8'h34);
    rdm(3'h0, 8'h10, 8'h10);
    // Sync lost first, then end of message; link stopped before each
    for (int k = 4; k < 9; k += 4) begin
      @(posedge clock) run <= 1'b1;
      sync_req <= 1'b1;
      repeat (60) @(posedge clock);
      rdm(3'h0, 8'h10, 8'h00);
      @(posedge clock) run <= 1'b0;
      sync_req <= 1'b0;
      settle;
      pulse(k);
      rdm(3'h0, 8'h10, 8'h10);
    end
    $display("test hunt done");
  endtask : t_hunt

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, ev} = '0;
    sys_rst = 1'b1;
    {tx_crc_active, other_int_pending, rx_parity_bad, rx_break} = '0;
    {rx_char_data, run, sync_req} = '0;
    {cd_n, cts_n, al_n} = 3'h7;
    err_count  = 0;
    n_compared = 0;
    t_reset;
    t_tx;
    t_async;
    t_hunt;
    results;
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    results;
  end
endmodule : serial_channel_status_regs_tb
